// >>> lcdo_limit_check.sv
// Limit check evaluator driving eight digital output lines
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module lcdo_limit_check #(
  parameter int NUM_PORTS = lcdo_pkg::NUM_PORTS,
  parameter int NUM_TERMS = lcdo_pkg::NUM_TERMS
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Register port
  input wire logic [lcdo_pkg::ADDR_W-1:0] i_addr,
  input wire logic [lcdo_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [lcdo_pkg::DATA_W-1:0] o_rdata,
  // Measurement input
  input wire logic i_meas_strobe,
  input wire lcdo_pkg::lcdo_meas_type i_meas,
  // Results
  output logic [NUM_PORTS-1:0] o_result,
  output logic o_busy,
  output logic [NUM_PORTS-1:0] o_dout,
  output logic [NUM_PORTS-1:0] o_dout_oe
);

  localparam int TOTAL = NUM_PORTS * NUM_TERMS;
  localparam int PW = $clog2(NUM_PORTS);
  localparam int TW = $clog2(NUM_TERMS);
  localparam logic [lcdo_pkg::TERM_AW-1:0] LAST_TERM = lcdo_pkg::TERM_AW'(TOTAL - 1);
  localparam logic [TW-1:0] LAST_IN_PORT = TW'(NUM_TERMS - 1);

  typedef enum logic {ST_IDLE, ST_RUN} lcdo_fsm_type;

  typedef struct packed {
    lcdo_fsm_type fsm;
    logic [2:0] ctrl;
    logic [lcdo_pkg::TERM_AW-1:0] term_idx;
    logic [lcdo_pkg::DATA_W-1:0] stage_lim;
    logic [TOTAL-1:0] term_valid;
    lcdo_pkg::lcdo_ser_cfg_type [NUM_PORTS-1:0] ser_cfg;
    logic [NUM_PORTS-1:0][lcdo_pkg::N_W-1:0] ser_cnt;
    logic [NUM_PORTS-1:0] res;
    logic [NUM_PORTS-1:0] raw;
    logic [NUM_PORTS-1:0] work;
    lcdo_pkg::lcdo_meas_type meas;
    logic [lcdo_pkg::TERM_AW-1:0] cnt;
    logic acc;
    logic chain;
    lcdo_pkg::lcdo_link_type link;
    logic [lcdo_pkg::DATA_W-1:0] rdata;
    logic [NUM_PORTS-1:0] dout;
    logic [NUM_PORTS-1:0] dout_oe;
  } lcdo_state_type;

  lcdo_state_type s_r;
  lcdo_state_type s_nxt;

  logic mem_we;
  logic [lcdo_pkg::TERM_AW-1:0] mem_raddr;
  logic [lcdo_pkg::TERM_W-1:0] mem_wdata;
  logic [lcdo_pkg::TERM_W-1:0] mem_rdata;

  // One step of the measurement-series shaping for one port
  function automatic lcdo_pkg::lcdo_ser_res_type series_step(
    input lcdo_pkg::lcdo_ser_cfg_type cfg,
    input logic [lcdo_pkg::N_W-1:0] cnt,
    input logic raw
  );
    lcdo_pkg::lcdo_ser_res_type r;
    logic tgt;
    logic [lcdo_pkg::N_W-1:0] n;
    n = (cfg.series_count_n == '0) ? lcdo_pkg::SER_N_RST : cfg.series_count_n;
    tgt = (cfg.mode == lcdo_pkg::SER_MIN_OK) || (cfg.mode == lcdo_pkg::SER_HOLD_OK) ||
          (cfg.mode == lcdo_pkg::SER_CYC_OK);
    r.cnt = cnt;
    r.out = raw;
    unique case (cfg.mode)
      lcdo_pkg::SER_OFF: begin
        r.cnt = '0;
        r.out = raw;
      end
      lcdo_pkg::SER_MIN_OK, lcdo_pkg::SER_MIN_FAIL: begin
        // Run length of the target result, saturating
        if (raw == tgt) begin
          r.cnt = (cnt == '1) ? cnt : cnt + lcdo_pkg::N_W'(1);
        end else begin
          r.cnt = '0;
        end
        r.out = (r.cnt >= n) ? tgt : ~tgt;
      end
      lcdo_pkg::SER_HOLD_OK, lcdo_pkg::SER_HOLD_FAIL: begin
        if (raw == tgt) begin
          r.cnt = n - lcdo_pkg::N_W'(1);
          r.out = tgt;
        end else if (cnt != '0) begin
          r.cnt = cnt - lcdo_pkg::N_W'(1);
          r.out = tgt;
        end else begin
          r.out = raw;
        end
      end
      lcdo_pkg::SER_CYC_OK, lcdo_pkg::SER_CYC_FAIL: begin
        if (cnt >= n - lcdo_pkg::N_W'(1)) begin
          r.cnt = '0;
          r.out = tgt;
        end else begin
          r.cnt = cnt + lcdo_pkg::N_W'(1);
          r.out = ~tgt;
        end
      end
      default: begin
        r.cnt = '0;
        r.out = raw;
      end
    endcase
    return r;
  endfunction : series_step

  lcdo_term_mem #(
    .DEPTH(TOTAL),
    .AW(lcdo_pkg::TERM_AW),
    .W(lcdo_pkg::TERM_W)
  ) u_term_mem (
    .i_clk_sys(i_clk_sys),
    .i_we(mem_we),
    .i_waddr(s_r.term_idx),
    .i_wdata(mem_wdata),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );

  // Term memory writes and the read address that runs one entry ahead
  always_comb begin
    mem_we = i_wr && (i_addr == lcdo_pkg::ADDR_TERM_CTL);
    mem_wdata = {s_r.stage_lim[lcdo_pkg::LIM_MAX_LSB +: lcdo_pkg::VAL_W],
                 s_r.stage_lim[lcdo_pkg::LIM_MIN_LSB +: lcdo_pkg::VAL_W],
                 i_wdata[lcdo_pkg::TCTL_LINK_LSB +: 2],
                 i_wdata[lcdo_pkg::TCTL_INV_BIT],
                 i_wdata[lcdo_pkg::TCTL_KIND_LSB +: 2],
                 i_wdata[lcdo_pkg::TCTL_SEL_LSB +: lcdo_pkg::SEL_W]};
    mem_raddr = (s_r.fsm == ST_IDLE) ? '0 : s_r.cnt + lcdo_pkg::TERM_AW'(1);
  end

  always_comb begin
    lcdo_pkg::lcdo_term_type t;
    logic signed [lcdo_pkg::VAL_W-1:0] v;
    logic hit;
    logic term;
    logic acc_new;
    logic [PW-1:0] port;
    logic [TW-1:0] tpos;
    lcdo_pkg::lcdo_ser_res_type sr;
    logic [NUM_PORTS-1:0] work_new;
    t = lcdo_pkg::lcdo_term_type'(mem_rdata);
    v = '0;
    hit = 1'b0;
    term = 1'b0;
    acc_new = 1'b0;
    port = s_r.cnt[lcdo_pkg::TERM_AW-1 -: PW];
    tpos = s_r.cnt[TW-1:0];
    sr = '0;
    work_new = s_r.work;
    s_nxt = s_r;

    // Register writes
    if (i_wr) begin
      if (i_addr == lcdo_pkg::ADDR_CTRL) begin
        s_nxt.ctrl = i_wdata[2:0];
      end else if (i_addr == lcdo_pkg::ADDR_TERM_IDX) begin
        s_nxt.term_idx = i_wdata[lcdo_pkg::TERM_AW-1:0];
      end else if (i_addr == lcdo_pkg::ADDR_TERM_LIM) begin
        s_nxt.stage_lim = i_wdata;
      end else if (i_addr == lcdo_pkg::ADDR_TERM_CTL) begin
        s_nxt.term_valid[s_r.term_idx] = 1'b1;
      end else if (i_addr[lcdo_pkg::ADDR_W-1:PW] ==
                   lcdo_pkg::ADDR_SERIES_BASE[lcdo_pkg::ADDR_W-1:PW]) begin
        s_nxt.ser_cfg[i_addr[PW-1:0]].mode =
          lcdo_pkg::lcdo_ser_mode_type'(i_wdata[lcdo_pkg::SER_MODE_LSB +: 3]);
        s_nxt.ser_cfg[i_addr[PW-1:0]].series_count_n =
          i_wdata[lcdo_pkg::SER_N_LSB +: lcdo_pkg::N_W];
        s_nxt.ser_cnt[i_addr[PW-1:0]] = '0;
      end
    end

    // Register reads, answered in the next cycle; unmapped reads give zero
    s_nxt.rdata = '0;
    if (i_rd) begin
      if (i_addr == lcdo_pkg::ADDR_CTRL) begin
        s_nxt.rdata[2:0] = s_r.ctrl;
      end else if (i_addr == lcdo_pkg::ADDR_STATUS) begin
        s_nxt.rdata[lcdo_pkg::STAT_RES_LSB +: NUM_PORTS] = s_r.res;
        s_nxt.rdata[lcdo_pkg::STAT_BUSY_BIT] = (s_r.fsm == ST_RUN);
        s_nxt.rdata[lcdo_pkg::STAT_RAW_LSB +: NUM_PORTS] = s_r.raw;
      end else if (i_addr == lcdo_pkg::ADDR_TERM_IDX) begin
        s_nxt.rdata[lcdo_pkg::TERM_AW-1:0] = s_r.term_idx;
      end else if (i_addr == lcdo_pkg::ADDR_TERM_LIM) begin
        s_nxt.rdata = s_r.stage_lim;
      end else if (i_addr[lcdo_pkg::ADDR_W-1:PW] ==
                   lcdo_pkg::ADDR_SERIES_BASE[lcdo_pkg::ADDR_W-1:PW]) begin
        s_nxt.rdata[lcdo_pkg::SER_MODE_LSB +: 3] = s_r.ser_cfg[i_addr[PW-1:0]].mode;
        s_nxt.rdata[lcdo_pkg::SER_N_LSB +: lcdo_pkg::N_W] =
          s_r.ser_cfg[i_addr[PW-1:0]].series_count_n;
      end
    end

    unique case (s_r.fsm)
      ST_IDLE: begin
        // Strobes during a running evaluation are ignored
        if (i_meas_strobe) begin
          s_nxt.fsm = ST_RUN;
          s_nxt.meas = i_meas;
          s_nxt.cnt = '0;
          s_nxt.work = s_r.res;
        end
      end
      ST_RUN: begin
        // Term evaluation, one term per cycle in ascending order
        if (!s_r.term_valid[s_r.cnt]) begin
          t = '0;
          t.lim_max = '1;
          t.lim_max[lcdo_pkg::VAL_W-1] = 1'b0;
          t.lim_min = '0;
          t.lim_min[lcdo_pkg::VAL_W-1] = 1'b1;
        end
        v = signed'(s_r.meas.value[t.sel]);
        unique case (t.kind)
          lcdo_pkg::KIND_RANGE: hit = (v >= t.lim_min) && (v <= t.lim_max);
          lcdo_pkg::KIND_STATUS: hit = ~s_r.meas.err[t.sel];
          lcdo_pkg::KIND_ALL_STATUS: hit = ~s_r.meas.err_all;
          lcdo_pkg::KIND_PORT: hit = s_r.work[t.sel[PW-1:0]];
        endcase
        term = hit ^ t.invert;
        if (tpos == '0) begin
          acc_new = term;
          s_nxt.chain = (t.link != lcdo_pkg::LINK_NONE);
        end else if (s_r.chain) begin
          unique case (s_r.link)
            lcdo_pkg::LINK_AND: acc_new = s_r.acc & term;
            lcdo_pkg::LINK_OR: acc_new = s_r.acc | term;
            lcdo_pkg::LINK_XOR: acc_new = s_r.acc ^ term;
            lcdo_pkg::LINK_NONE: acc_new = s_r.acc;
          endcase
          s_nxt.chain = (t.link != lcdo_pkg::LINK_NONE);
        end else begin
          acc_new = s_r.acc;
        end
        s_nxt.acc = acc_new;
        s_nxt.link = t.link;

        // Close the port after its last term
        if (tpos == LAST_IN_PORT) begin
          sr = series_step(s_r.ser_cfg[port], s_r.ser_cnt[port], acc_new);
          s_nxt.ser_cnt[port] = sr.cnt;
          s_nxt.raw[port] = acc_new;
          work_new[port] = sr.out;
          s_nxt.work = work_new;
        end
        if (s_r.cnt == LAST_TERM) begin
          s_nxt.fsm = ST_IDLE;
          s_nxt.res = work_new;
        end else begin
          s_nxt.cnt = s_r.cnt + lcdo_pkg::TERM_AW'(1);
        end
      end
    endcase

    // Output lines follow the committed results only
    if (s_nxt.ctrl[lcdo_pkg::CTRL_IFACE_BIT] && s_nxt.ctrl[lcdo_pkg::CTRL_ACTIVE_BIT]) begin
      s_nxt.dout = s_nxt.res ^ {NUM_PORTS{s_nxt.ctrl[lcdo_pkg::CTRL_INVLVL_BIT]}};
      s_nxt.dout_oe = '1;
    end else begin
      s_nxt.dout = '0;
      s_nxt.dout_oe = '0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.fsm <= ST_IDLE;
      s_r.ctrl <= lcdo_pkg::CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata = s_r.rdata;
  assign o_result = s_r.res;
  assign o_busy = (s_r.fsm == ST_RUN);
  assign o_dout = s_r.dout;
  assign o_dout_oe = s_r.dout_oe;

endmodule : lcdo_limit_check

`default_nettype wire

// >>> lcdo_limit_check_props.sv
// Concurrent property checker for the limit check output block
`timescale 1ns/1ps
`default_nettype none

module lcdo_limit_check_props #(
  parameter int NUM_PORTS = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Register port
  input wire logic [lcdo_pkg::ADDR_W-1:0] i_addr,
  input wire logic [lcdo_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [lcdo_pkg::DATA_W-1:0] o_rdata,
  // Measurement and lines
  input wire logic i_meas_strobe,
  input wire logic [NUM_PORTS-1:0] o_result,
  input wire logic o_busy,
  input wire logic [NUM_PORTS-1:0] o_dout,
  input wire logic [NUM_PORTS-1:0] o_dout_oe
);
  logic [2:0] ctl_r;
  logic [6:0] run_r;
  logic en;

  // Shadow of the control register and length of the current evaluation
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ctl_r <= 3'h0;
      run_r <= 7'h00;
    end else begin
      if (i_wr && i_addr == lcdo_pkg::ADDR_CTRL) ctl_r <= i_wdata[2:0];
      run_r <= o_busy ? run_r + 7'h01 : 7'h00;
    end
  end
  assign en = ctl_r[0] & ctl_r[1];

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_take;
    i_meas_strobe && !o_busy;
  endsequence
  sequence s_run;
    o_busy [*8];
  endsequence

  AST_BUSY_START: assert property (s_take |=> s_run)
    else $error("evaluation did not start after a taken strobe");
  AST_BUSY_MAX: assert property (o_busy |-> run_r <= 7'h3F)
    else $error("evaluation runs longer than 64 cycles");
  AST_BUSY_LEN: assert property ($fell(o_busy) |-> run_r == 7'h40)
    else $error("evaluation ended early");
  AST_IDLE_HOLD: assert property (!o_busy && !i_meas_strobe |=> !o_busy)
    else $error("evaluation started without a strobe");
  AST_RES_HOLD: assert property (!$fell(o_busy) |-> $stable(o_result))
    else $error("result changed outside the end of an evaluation");
  AST_DOUT: assert property (ctl_r == $past(ctl_r) |->
    o_dout == (en ? o_result ^ {NUM_PORTS{ctl_r[2]}} : '0))
    else $error("line levels differ from results and control");
  AST_OE: assert property (ctl_r == $past(ctl_r) |-> o_dout_oe == {NUM_PORTS{en}})
    else $error("line enables differ from control");
  AST_STAT_RD: assert property (i_rd && i_addr == lcdo_pkg::ADDR_STATUS |=>
    o_rdata[NUM_PORTS-1:0] == $past(o_result) &&
    o_rdata[lcdo_pkg::STAT_BUSY_BIT] == $past(o_busy))
    else $error("status read does not show results");
  AST_CTRL_RD: assert property (i_rd && i_addr == lcdo_pkg::ADDR_CTRL |=>
    o_rdata == {29'h0, $past(ctl_r)})
    else $error("control read does not match last write");
endmodule : lcdo_limit_check_props

bind lcdo_limit_check lcdo_limit_check_props #(.NUM_PORTS(NUM_PORTS)) props_u (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_meas_strobe(i_meas_strobe),
  .o_result(o_result), .o_busy(o_busy), .o_dout(o_dout), .o_dout_oe(o_dout_oe)
);
`default_nettype wire

// >>> lcdo_line_sampler.sv
// External controller model sampling the digital output lines
`timescale 1ns/1ps
`default_nettype none

module lcdo_line_sampler (
  // Clock
  input wire logic i_clk_sys,
  // Output lines
  input wire logic [7:0] i_line,
  input wire logic [7:0] i_line_oe,
  // Sampled levels
  output var logic [7:0] o_level
);
  // Undriven lines fall to the pull-down level
  always_ff @(posedge i_clk_sys) begin
    o_level <= i_line & i_line_oe;
  end
endmodule : lcdo_line_sampler
`default_nettype wire

// >>> lcdo_pkg.sv
// Package: constants, register map and carrier types of the limit check output block
package lcdo_pkg;

  // Sizes
  localparam int NUM_PORTS = 8;
  localparam int NUM_TERMS = 8;
  localparam int NUM_SRC = 16;
  localparam int VAL_W = 16;
  localparam int SEL_W = 4;
  localparam int N_W = 8;
  localparam int TERM_AW = 6;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register word addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_TERM_IDX = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_TERM_LIM = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_TERM_CTL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SERIES_BASE = 8'h10;

  // Control register fields
  localparam int CTRL_IFACE_BIT = 0;
  localparam int CTRL_ACTIVE_BIT = 1;
  localparam int CTRL_INVLVL_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // Status register fields
  localparam int STAT_RES_LSB = 0;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_RAW_LSB = 16;

  // Limit register fields
  localparam int LIM_MIN_LSB = 0;
  localparam int LIM_MAX_LSB = 16;

  // Term control register fields
  localparam int TCTL_SEL_LSB = 0;
  localparam int TCTL_KIND_LSB = 4;
  localparam int TCTL_INV_BIT = 6;
  localparam int TCTL_LINK_LSB = 8;

  // Series register fields
  localparam int SER_MODE_LSB = 0;
  localparam int SER_N_LSB = 8;
  localparam logic [N_W-1:0] SER_N_RST = 8'h01;

  typedef enum logic [1:0] {LINK_NONE, LINK_AND, LINK_OR, LINK_XOR} lcdo_link_type;
  typedef enum logic [1:0] {KIND_RANGE, KIND_STATUS, KIND_ALL_STATUS, KIND_PORT} lcdo_kind_type;
  typedef enum logic [2:0] {
    SER_OFF, SER_MIN_OK, SER_MIN_FAIL, SER_HOLD_OK, SER_HOLD_FAIL, SER_CYC_OK, SER_CYC_FAIL
  } lcdo_ser_mode_type;

  typedef struct packed {
    logic signed [VAL_W-1:0] lim_max;
    logic signed [VAL_W-1:0] lim_min;
    lcdo_link_type link;
    logic invert;
    lcdo_kind_type kind;
    logic [SEL_W-1:0] sel;
  } lcdo_term_type;

  localparam int TERM_W = $bits(lcdo_term_type);

  typedef struct packed {
    lcdo_ser_mode_type mode;
    logic [N_W-1:0] series_count_n;
  } lcdo_ser_cfg_type;

  typedef struct packed {
    logic [N_W-1:0] cnt;
    logic out;
  } lcdo_ser_res_type;

  typedef struct packed {
    logic [NUM_SRC-1:0][VAL_W-1:0] value;
    logic [NUM_SRC-1:0] err;
    logic err_all;
  } lcdo_meas_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } lcdo_bus_type;

endpackage : lcdo_pkg

// >>> lcdo_term_mem.sv
// Term configuration memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module lcdo_term_mem #(
  parameter int DEPTH = 64,
  parameter int AW = 6,
  parameter int W = 41
) (
  // Clock
  input wire logic i_clk_sys,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  // Read port
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule : lcdo_term_mem

`default_nettype wire

// >>> test_lcdo_limit_check.sv
// Self-checking testbench of the limit check output block
`timescale 1ns/1ps
`default_nettype none

module test_lcdo_limit_check;
  logic clk, rst_n, wr, rd, stb, busy, r, x6, x7;
  logic [7:0] addr, res, dout, oe, lvl, e;
  logic [31:0] wdata, rdata;
  logic [2:0] ctl;
  lcdo_pkg::lcdo_meas_type meas, m;
  int error_cnt, samples_checked, c, h;

  lcdo_limit_check dut_u (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_meas_strobe(stb), .i_meas(meas), .o_result(res),
    .o_busy(busy), .o_dout(dout), .o_dout_oe(oe)
  );
  lcdo_line_sampler ext_u (.i_clk_sys(clk), .i_line(dout), .i_line_oe(oe), .o_level(lvl));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    samples_checked++;
    if (g !== ex) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, ex, g);
    end
  endtask : chk

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr32

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, ex, rdata);
  endtask : rd_chk

  task automatic term(input logic [5:0] i, input logic [31:0] lim, input logic [9:0] cw);
    wr32(lcdo_pkg::ADDR_TERM_IDX, {26'h0, i});
    wr32(lcdo_pkg::ADDR_TERM_LIM, lim);
    wr32(lcdo_pkg::ADDR_TERM_CTL, {22'h0, cw});
  endtask : term

  // One measurement, a strobe while busy that must be ignored, then checks
  task automatic run(input lcdo_pkg::lcdo_meas_type mv, input logic [7:0] ex,
                     input logic [7:0] raw);
    logic [7:0] ln;
    int n;
    ln = (ctl[0] & ctl[1]) ? ex ^ {8{ctl[2]}} : 8'h00;
    n = 0;
    @(posedge clk);
    stb <= 1'b1;
    meas <= mv;
    @(posedge clk);
    stb <= 1'b0;
    repeat (9) @(posedge clk);
    stb <= 1'b1;
    meas <= ~mv;
    @(posedge clk);
    stb <= 1'b0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (2) @(posedge clk);
    #1;
    chk("busy", 32'h0000_0000, {31'h0, busy});
    chk("result", {24'h0, ex}, {24'h0, res});
    chk("lines", {24'h0, ln}, {24'h0, dout});
    chk("line_oe", {24'h0, {8{ctl[0] & ctl[1]}}}, {24'h0, oe});
    chk("sampled", {24'h0, ln}, {24'h0, lvl});
    rd_chk("status", lcdo_pkg::ADDR_STATUS, {8'h0, raw, 8'h0, ex});
  endtask : run

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    stb = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    meas = '0;
    ctl = 3'h0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("ctrl_rst", lcdo_pkg::ADDR_CTRL, 32'h0000_0000);
    rd_chk("status_rst", lcdo_pkg::ADDR_STATUS, 32'h0000_0000);
    rd_chk("unmapped", 8'h20, 32'h0000_0000);
    term(6'h00, 32'h0008_FFFB, 10'h000);
    rd_chk("limits", lcdo_pkg::ADDR_TERM_LIM, 32'h0008_FFFB);
    rd_chk("term_ctl", lcdo_pkg::ADDR_TERM_CTL, 32'h0000_0000);
    term(6'h08, 32'h0008_FFFB, 10'h040);
    term(6'h10, 32'h0000_0000, 10'h011);
    term(6'h18, 32'h0000_0000, 10'h060);
    // Port 4 chain: XOR, OR, AND, end; the term after the end is ignored
    term(6'h20, 32'h0000_0000, 10'h312);
    term(6'h21, 32'h0000_0000, 10'h213);
    term(6'h22, 32'h0000_0000, 10'h114);
    term(6'h23, 32'h0000_0000, 10'h015);
    term(6'h24, 32'h0000_0000, 10'h060);
    term(6'h28, 32'h0000_0000, 10'h030);
    for (int i = 0; i < 16; i++) begin
      ctl = i[2:0];
      wr32(lcdo_pkg::ADDR_CTRL, {29'h0, ctl});
      rd_chk("ctrl", lcdo_pkg::ADDR_CTRL, {29'h0, ctl});
      m = '0;
      m.value[0] = 16'(i - 6);
      m.err[5:1] = {i[3:0], i[0]};
      m.err_all = i[1];
      r = (i >= 1) && (i <= 14);
      e = {2'b11, r, ((!i[0] ^ !i[1]) | !i[2]) & !i[3], i[1], !i[0], !r, r};
      run(m, e, e);
    end
    term(6'h30, 32'h0000_0000, 10'h016);
    term(6'h38, 32'h0000_0000, 10'h016);
    wr32(8'h16, 32'h0000_0301);
    wr32(8'h17, 32'h0000_0204);
    rd_chk("series", 8'h16, 32'h0000_0301);
    ctl = 3'h3;
    wr32(lcdo_pkg::ADDR_CTRL, {29'h0, ctl});
    c = 0;
    h = 0;
    for (int j = 0; j < 12; j++) begin
      r = 1'(12'hEF6 >> j);
      c = r ? c + 1 : 0;
      x6 = (c >= 3);
      if (!r) begin
        h = 1;
        x7 = 1'b0;
      end else if (h > 0) begin
        h--;
        x7 = 1'b0;
      end else begin
        x7 = 1'b1;
      end
      m = '0;
      m.err[6] = !r;
      run(m, {x7, x6, 6'h35}, {r, r, 6'h35});
    end
    // Cyclic OK with minimum count fail, then cyclic fail with hold OK
    for (int q = 0; q < 2; q++) begin
      wr32(8'h16, (q == 0) ? 32'h0000_0305 : 32'h0000_0206);
      wr32(8'h17, (q == 0) ? 32'h0000_0202 : 32'h0000_0303);
      c = 0;
      h = 0;
      for (int j = 0; j < 12; j++) begin
        r = 1'(12'hD89 >> j);
        x6 = ((j % (3 - q)) == (2 - q)) ? (q == 0) : (q != 0);
        if (q == 0) begin
          c = r ? 0 : c + 1;
          x7 = (c < 2);
        end else if (r) begin
          h = 2;
          x7 = 1'b1;
        end else begin
          x7 = (h > 0);
          h = (h > 0) ? h - 1 : 0;
        end
        m = '0;
        m.err[6] = !r;
        run(m, {x7, x6, 6'h35}, {r, r, 6'h35});
      end
    end
    give_verdict();
  end
endmodule : test_lcdo_limit_check
`default_nettype wire
